// ==== srt_map.vh ====
`ifndef SRT_MAP_VH
`define SRT_MAP_VH

// ------------------------------
// register addresses
// ------------------------------
`define SRT_A_LINES 7'h01
`define SRT_A_MODE 7'h46
`define SRT_A_EXP_LO 7'h47
`define SRT_A_EXP_HI 7'h48
`define SRT_A_FRAMES 7'h50
`define SRT_A_OVH 7'h52
`define SRT_A_LEN 7'h55
`define SRT_A_TP 7'h59
`define SRT_A_CFG 7'h60
`define SRT_A_STAT 7'h61

// ------------------------------
// reset values
// ------------------------------
`define SRT_R_LINES 16'h0c00
`define SRT_R_MODE 8'h00
`define SRT_R_EXP_LO 16'h0600
`define SRT_R_EXP_HI 8'h00
`define SRT_R_FRAMES 16'h0001
`define SRT_R_CFG 16'h0000

// ------------------------------
// configuration fields
// ------------------------------
`define SRT_CFG_BITS 1:0
`define SRT_CFG_OUTS 4:2
`define SRT_CFG_ONE_SIDE 5
`define SRT_CFG_RDMODE 7:6
`define SRT_CFG_CONT 8

// ------------------------------
// word formats and timing
// ------------------------------
`define SRT_BITS_8 4'h8
`define SRT_BITS_10 4'ha
`define SRT_BITS_12 4'hc
`define SRT_MASK_8 12'h0ff
`define SRT_MASK_10 12'h3ff
`define SRT_MASK_12 12'hfff
`define SRT_OVL_MUL 16'h0022
`define SRT_BURST 16'h0080
`define SRT_FOT_ADD 8'h02
`define SRT_MARKER_BIT 7
`define SRT_CTRL_REST 12'h080
`define SRT_SPI_LEN 5'h17
`define SRT_SPI_HDR 5'h08

`endif

// ==== srt_sync_edge.v ====
`timescale 1ns/1ps
module srt_sync_edge (
    input wire clk_i,
    input wire rst_i,
    input wire d_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign level_o = s2;
    assign rise_o = s2 & ~s3;
    assign fall_o = ~s2 & s3;
endmodule // srt_sync_edge

// ==== srt_timing.v ====
// Function
// R1: receiver decodes valid flags from low bits
// R2: sixteen outputs doubles row time and flags
// R3: fewer outputs scale timing proportionally
// R4: training word whenever no valid pixels
// R5: training word width follows pixel width
// R6: idle word from writable register 89
// R7: alignment word inverts low byte, clears top
// R8: alignment word one slot before line valid
// R9: longer gaps filled with idle word
// R10: line valid without pixel valid: idle word
// R11: control idle word is only marker bit
// R12: external exposure from trigger to request
// R13: address 70 selects exposure mode
// R14: internal exposure length at 71 and 72
// R15: internal exposure formula in word periods
// R16: external exposure quantized to word periods
// R17: exposure overlaps overhead by 34 times low
// R18: line time is line length plus one
// R19: overhead period is upper byte plus two
// R20: readout rows by mode and sides
// R21: frames per request, one when external
// R22: control bit positions of flags
// R23: total lines register at address 1
// R24: receiver aligns on idle word
`timescale 1ns/1ps
`include "srt_map.vh"
module srt_timing #(
    parameter OVH_RST = 16'h0001,
    parameter LEN_RST = 16'h0080,
    parameter TP_RST = 12'h055
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire spi_clk_i,
    input wire spi_cs_n_i,
    input wire spi_mosi_i,
    output wire spi_miso_o,
    output wire spi_miso_oe_o,
    input wire frame_req_i,
    input wire exposure_start_trigger_i,
    input wire [11:0] pixel_data_i,
    output reg [11:0] ctrl_word_o,
    output reg [11:0] data_word_o,
    output reg word_strobe_o
);
    // ------------------------------
    // state codes
    // ------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_EXP = 3'h1;
    localparam ST_EXT = 3'h2;
    localparam ST_FOT = 3'h3;
    localparam ST_READ = 3'h4;
    localparam [15:0] CFG_RST = `SRT_R_CFG;

    // ------------------------------
    // pin synchronisers
    // ------------------------------
    wire sck_rise;
    wire sck_fall;
    wire cs_n;
    wire cs_sel;
    wire mosi;
    wire req_rise;
    wire trig_rise;

    srt_sync_edge u_sck (.clk_i(ref_clk_i), .rst_i(rst_i), .d_i(spi_clk_i),
        .level_o(), .rise_o(sck_rise), .fall_o(sck_fall));
    // select synchronised inverted: reset reads as deselected, no output enable glitch
    srt_sync_edge u_cs (.clk_i(ref_clk_i), .rst_i(rst_i), .d_i(~spi_cs_n_i),
        .level_o(cs_sel), .rise_o(), .fall_o());
    srt_sync_edge u_mosi (.clk_i(ref_clk_i), .rst_i(rst_i), .d_i(spi_mosi_i),
        .level_o(mosi), .rise_o(), .fall_o());
    srt_sync_edge u_req (.clk_i(ref_clk_i), .rst_i(rst_i), .d_i(frame_req_i),
        .level_o(), .rise_o(req_rise), .fall_o());
    srt_sync_edge u_trig (.clk_i(ref_clk_i), .rst_i(rst_i), .d_i(exposure_start_trigger_i),
        .level_o(), .rise_o(trig_rise), .fall_o());
    assign cs_n = ~cs_sel;

    // ------------------------------
    // configuration registers
    // ------------------------------
    reg [15:0] r_lines;
    reg [7:0] r_mode;
    reg [15:0] r_exp_lo;
    reg [7:0] r_exp_hi;
    reg [15:0] r_frames;
    reg [15:0] r_ovh;
    reg [15:0] r_len;
    reg [11:0] r_tp;
    reg [15:0] r_cfg;
    reg [2:0] st;

    // ------------------------------
    // serial port
    // ------------------------------
    // frame: write flag, 7-bit address, 16-bit data, msb first
    reg [4:0] spi_cnt;
    reg [22:0] spi_sh;
    reg [15:0] rd_sh;
    reg [15:0] rd_val;
    wire wr_go;
    wire [6:0] wr_addr;
    wire [15:0] wr_data;

    assign wr_go = sck_rise & ~cs_n & (spi_cnt == `SRT_SPI_LEN) & spi_sh[22];
    assign wr_addr = spi_sh[21:15];
    assign wr_data = {spi_sh[14:0], mosi};
    assign spi_miso_o = rd_sh[15];
    assign spi_miso_oe_o = ~cs_n;

    always @* begin
        case (spi_sh[6:0])
            `SRT_A_LINES: rd_val = r_lines;
            `SRT_A_MODE: rd_val = {8'h00, r_mode};
            `SRT_A_EXP_LO: rd_val = r_exp_lo;
            `SRT_A_EXP_HI: rd_val = {8'h00, r_exp_hi};
            `SRT_A_FRAMES: rd_val = r_frames;
            `SRT_A_OVH: rd_val = r_ovh;
            `SRT_A_LEN: rd_val = r_len;
            `SRT_A_TP: rd_val = {4'h0, r_tp};
            `SRT_A_CFG: rd_val = r_cfg;
            `SRT_A_STAT: rd_val = {13'h0000, st};
            default: rd_val = 16'h0000;
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            spi_cnt <= 5'h00;
            spi_sh <= 23'h000000;
            rd_sh <= 16'h0000;
        end else if (cs_n) begin
            spi_cnt <= 5'h00;
            rd_sh <= 16'h0000;
        end else if (sck_rise) begin
            spi_sh <= {spi_sh[21:0], mosi};
            spi_cnt <= spi_cnt + 5'h01;
        end else if (sck_fall) begin
            // header complete: load readback before first data bit
            if (spi_cnt == `SRT_SPI_HDR) begin
                rd_sh <= rd_val;
            end else begin
                rd_sh <= {rd_sh[14:0], 1'b0};
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            r_lines <= `SRT_R_LINES; // see R23
            r_mode <= `SRT_R_MODE; // see R13
            r_exp_lo <= `SRT_R_EXP_LO; // see R14
            r_exp_hi <= `SRT_R_EXP_HI;
            r_frames <= `SRT_R_FRAMES;
            r_ovh <= OVH_RST;
            r_len <= LEN_RST;
            r_tp <= TP_RST;
            r_cfg <= `SRT_R_CFG;
        end else if (wr_go) begin
            case (wr_addr)
                `SRT_A_LINES: r_lines <= wr_data;
                `SRT_A_MODE: r_mode <= wr_data[7:0];
                `SRT_A_EXP_LO: r_exp_lo <= wr_data;
                `SRT_A_EXP_HI: r_exp_hi <= wr_data[7:0];
                `SRT_A_FRAMES: r_frames <= wr_data;
                `SRT_A_OVH: r_ovh <= wr_data;
                `SRT_A_LEN: r_len <= wr_data;
                `SRT_A_TP: r_tp <= wr_data[11:0]; // see R6
                `SRT_A_CFG: r_cfg <= wr_data;
                default: r_lines <= r_lines;
            endcase
        end
    end

    // ------------------------------
    // word period
    // ------------------------------
    reg [3:0] bits;
    reg [11:0] wmask;
    reg [3:0] bit_cnt;
    reg [1:0] wsel;
    wire tick;

    always @* begin
        case (wsel)
            2'h0: begin
                bits = `SRT_BITS_8;
                wmask = `SRT_MASK_8;
            end
            2'h1: begin
                bits = `SRT_BITS_10;
                wmask = `SRT_MASK_10;
            end
            default: begin
                bits = `SRT_BITS_12;
                wmask = `SRT_MASK_12;
            end
        endcase
    end

    // every interval is counted in whole word periods
    assign tick = (bit_cnt >= bits - 4'h1); // see R16

    always @(posedge ref_clk_i) begin
        if (rst_i || tick) begin
            bit_cnt <= 4'h0;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // width follows the register only on a boundary, so no word is cut short
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            wsel <= CFG_RST[`SRT_CFG_BITS];
        end else if (tick) begin
            wsel <= r_cfg[`SRT_CFG_BITS];
        end
    end

    // ------------------------------
    // derived timing
    // ------------------------------
    wire ext_mode;
    wire [23:0] exp_val;
    wire [23:0] exp_m1;
    wire [16:0] line_words;
    wire [39:0] exp_pre;
    wire [23:0] fot_words;
    wire [15:0] ovl_words;
    wire [5:0] scale;
    wire [15:0] rows_m;
    wire [15:0] rows;
    wire [15:0] frames;

    assign ext_mode = (r_mode == 8'h01); // see R13
    assign exp_val = {r_exp_hi, r_exp_lo}; // see R14
    assign exp_m1 = (exp_val == 24'h000000) ? 24'h000000 : exp_val - 24'h000001;
    assign line_words = {1'b0, r_len} + 17'h00001; // see R18
    // overlap part is counted during the overhead period
    assign exp_pre = exp_m1 * line_words + 40'h0000000001; // see R15
    assign ovl_words = `SRT_OVL_MUL * {8'h00, r_ovh[7:0]}; // see R17
    assign fot_words = ({16'h0000, r_ovh[15:8]} + {16'h0000, `SRT_FOT_ADD}) * {7'h00, line_words}; // see R19
    // row spans one line time per 32 outputs on a side
    assign scale = 6'h01 << r_cfg[`SRT_CFG_OUTS]; // see R2 R3
    assign rows_m = r_lines >> r_cfg[`SRT_CFG_RDMODE]; // see R20
    assign rows = r_cfg[`SRT_CFG_ONE_SIDE] ? rows_m : (rows_m >> 1);
    assign frames = (r_frames == 16'h0000) ? 16'h0001 : r_frames; // see R21

    // ------------------------------
    // sequencer
    // ------------------------------
    reg [39:0] cnt;
    reg [15:0] ovl_cnt;
    reg [15:0] frames_left;
    reg [15:0] row_left;
    reg [5:0] seg;
    reg [16:0] pos;
    reg req_pend;
    reg trig_pend;
    wire req_use;
    wire trig_use;
    wire last_word;

    // requests outside idle or external exposure are held pending until one of them is reached
    assign req_use = tick & ((st == ST_IDLE) | (st == ST_EXT));
    assign trig_use = tick & (st == ST_IDLE);
    assign last_word = (pos == {1'b0, r_len}) && (seg == scale - 6'h01) && (row_left <= 16'h0001);

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            req_pend <= 1'b0;
            trig_pend <= 1'b0;
        end else begin
            // an edge in the consuming cycle survives
            req_pend <= req_rise | (req_pend & ~req_use);
            trig_pend <= trig_rise | (trig_pend & ~trig_use);
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            st <= ST_IDLE;
            cnt <= 40'h0000000000;
            ovl_cnt <= 16'h0000;
            frames_left <= 16'h0000;
            row_left <= 16'h0000;
            seg <= 6'h00;
            pos <= 17'h00000;
        end else if (tick) begin
            if (ovl_cnt != 16'h0000) begin
                ovl_cnt <= ovl_cnt - 16'h0001;
            end
            case (st)
                ST_IDLE: begin
                    if (!ext_mode && req_pend) begin
                        st <= ST_EXP;
                        cnt <= exp_pre;
                        frames_left <= frames; // see R21
                    end else if (ext_mode && trig_pend) begin
                        st <= ST_EXT; // see R12
                    end
                end
                ST_EXP: begin
                    if (cnt <= 40'h0000000001) begin
                        st <= ST_FOT;
                        cnt <= {16'h0000, fot_words};
                        ovl_cnt <= ovl_words; // see R17
                    end else begin
                        cnt <= cnt - 40'h0000000001;
                    end
                end
                ST_EXT: begin
                    // request ends exposure on a word boundary
                    if (req_pend) begin
                        st <= ST_FOT; // see R12 R16
                        cnt <= {16'h0000, fot_words};
                        ovl_cnt <= ovl_words;
                    end
                end
                ST_FOT: begin
                    if (cnt <= 40'h0000000001) begin
                        st <= ST_READ;
                        row_left <= (rows == 16'h0000) ? 16'h0001 : rows;
                        seg <= 6'h00;
                        pos <= 17'h00000;
                    end else begin
                        cnt <= cnt - 40'h0000000001;
                    end
                end
                ST_READ: begin
                    if (pos == {1'b0, r_len}) begin
                        pos <= 17'h00000;
                        if (seg == scale - 6'h01) begin
                            seg <= 6'h00;
                            row_left <= row_left - 16'h0001;
                        end else begin
                            seg <= seg + 6'h01;
                        end
                    end else begin
                        pos <= pos + 17'h00001;
                    end
                    if (last_word) begin
                        if (!ext_mode && frames_left > 16'h0001) begin
                            st <= ST_EXP;
                            cnt <= exp_pre;
                            frames_left <= frames_left - 16'h0001;
                        end else if (r_cfg[`SRT_CFG_CONT]) begin
                            st <= ext_mode ? ST_EXT : ST_EXP; // see R21
                            cnt <= exp_pre;
                        end else begin
                            st <= ST_IDLE;
                        end
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------
    // output words
    // ------------------------------
    wire pv;
    wire lv;
    wire fv;
    wire frame_overhead_period;
    wire integ;
    wire align_slot;
    wire [11:0] tp_idle;
    wire [11:0] tp_align;
    reg [11:0] next_data;
    reg [11:0] next_ctrl;

    assign fv = (st == ST_READ);
    // the row's first slot carries the alignment word
    assign align_slot = fv && (pos == 17'h00000) && (seg == 6'h00);
    assign lv = fv && !align_slot; // see R2 R8
    assign pv = fv && (pos != 17'h00000) && (pos <= {1'b0, `SRT_BURST}); // see R3
    assign frame_overhead_period = (st == ST_FOT);
    assign integ = (st == ST_EXP) || (st == ST_EXT) || (ovl_cnt != 16'h0000);
    assign tp_idle = r_tp & wmask; // see R5
    assign tp_align = {4'h0, ~r_tp[7:0]} & wmask; // see R7

    always @* begin
        if (pv) begin
            next_data = pixel_data_i & wmask;
        end else if (align_slot) begin
            next_data = tp_align; // see R8
        end else begin
            // idle, overhead gaps and blanking within a row
            next_data = tp_idle; // see R4 R9 R10
        end
        next_ctrl = 12'h000; // see R11
        next_ctrl[`SRT_MARKER_BIT] = 1'b1;
        next_ctrl[5:0] = {integ, integ, frame_overhead_period, fv, lv, pv}; // see R22 R1
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_word_o <= TP_RST;
            ctrl_word_o <= `SRT_CTRL_REST;
            word_strobe_o <= 1'b0;
        end else begin
            // words move only on a boundary, together with the strobe
            if (tick) begin
                data_word_o <= next_data;
                ctrl_word_o <= next_ctrl & wmask;
            end
            word_strobe_o <= tick;
        end
    end
endmodule // srt_timing

// ==== srt_timing_chk.sv ====
`timescale 1ns/1ps
module srt_timing_chk #(
    parameter OVH_RST = 16'h0001,
    parameter LEN_RST = 16'h0080,
    parameter TP_RST = 12'h055
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire [11:0] ctrl_word_o,
    input wire [11:0] data_word_o,
    input wire word_strobe_o
);
    // ------------------------------
    // word history
    // ------------------------------
    // idle word is learnt from the lanes, so a register write needs one rest word
    reg [11:0] idle_seen;
    reg [11:0] prev_data;
    reg prev_lv;
    wire [11:0] align_w = {4'h0, ~idle_seen[7:0]};
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            idle_seen <= TP_RST & 12'h0ff;
            prev_data <= 12'h000;
            prev_lv <= 1'b0;
        end else if (word_strobe_o) begin
            if (ctrl_word_o == 12'h080) idle_seen <= data_word_o;
            prev_data <= data_word_o;
            prev_lv <= ctrl_word_o[1];
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_ctrl_fixed: assert property (ctrl_word_o[11:6] == 6'h02)
        else $error("control fixed bits wrong");
    a_pv_in_line: assert property (ctrl_word_o[0] |-> ctrl_word_o[2:1] == 2'b11)
        else $error("pixel flag outside line");
    a_ovh_no_line: assert property (ctrl_word_o[3] |-> !ctrl_word_o[1])
        else $error("line during overhead");
    a_word_hold: assert property ($changed(ctrl_word_o) || $changed(data_word_o) |-> ##[0:1] word_strobe_o)
        else $error("words changed off boundary");
    a_strobe_gap: assert property (word_strobe_o |=> !word_strobe_o [*7])
        else $error("word shorter than 8 bits");
    a_strobe_period: assert property (word_strobe_o |-> ##[8:12] word_strobe_o)
        else $error("word period off");
    a_align_first: assert property (word_strobe_o && ctrl_word_o[1] && !prev_lv |-> prev_data == align_w)
        else $error("no alignment word before line");
    a_line_idle: assert property (word_strobe_o && ctrl_word_o[1] && !ctrl_word_o[0] |-> data_word_o == idle_seen)
        else $error("line gap not idle word");
    a_gap_train: assert property (word_strobe_o && !ctrl_word_o[1] && ctrl_word_o[7:0] != 8'h80
        |-> data_word_o == idle_seen || data_word_o == align_w)
        else $error("gap not training word");
endmodule // srt_timing_chk
bind srt_timing srt_timing_chk #(.OVH_RST(OVH_RST), .LEN_RST(LEN_RST), .TP_RST(TP_RST)) chk (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ctrl_word_o(ctrl_word_o),
    .data_word_o(data_word_o),
    .word_strobe_o(word_strobe_o)
);

// ==== srt_rx_model.sv ====
`timescale 1ns/1ps
module srt_rx_model (
    input wire ref_clk_i,
    input wire rst_i,
    input wire word_strobe_i,
    input wire [11:0] ctrl_word_i,
    input wire [11:0] data_word_i,
    input wire [11:0] idle_word_i,
    input wire [11:0] align_word_i,
    input wire [11:0] pix_word_i
);
    // 0 pixel, 1 line, 2 frame start, 3 integ, 4 overhead, 5 align, 6 frame end, 7 wrong, 8 idle lock
    integer cnt [0:8];
    integer i;
    reg last_fv;
    wire pv = ctrl_word_i[0];
    wire lv = ctrl_word_i[1];
    wire fv = ctrl_word_i[2];
    wire aln = data_word_i == align_word_i && !lv;
    wire bad = pv ? data_word_i != pix_word_i : data_word_i != idle_word_i && !aln;
    function integer f(input b);
        f = b ? 1 : 0;
    endfunction
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (i = 0; i < 9; i = i + 1) cnt[i] <= 0;
            last_fv <= 1'b0;
        end else if (word_strobe_i) begin
            last_fv <= fv;
            cnt[0] <= cnt[0] + f(pv);
            cnt[1] <= cnt[1] + f(lv);
            cnt[2] <= cnt[2] + f(fv && !last_fv);
            cnt[3] <= cnt[3] + f(ctrl_word_i[4]);
            cnt[4] <= cnt[4] + f(ctrl_word_i[3]);
            cnt[5] <= cnt[5] + f(aln);
            cnt[6] <= cnt[6] + f(!fv && last_fv);
            cnt[7] <= cnt[7] + f(bad);
            // lock search runs at every rest, so drift is picked up again
            cnt[8] <= cnt[8] + f(ctrl_word_i == 12'h080 && data_word_i == idle_word_i);
        end
    end
endmodule // srt_rx_model

// ==== tb.sv ====
`timescale 1ns/1ps
`include "srt_map.vh"
module tb;
    localparam integer LEN = 128;
    localparam integer EXP = 2;
    localparam integer INTEG = (EXP - 1) * (LEN + 1) + 1 + 34;
    localparam integer OVH = 2 * (LEN + 1);
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic spi_clk_i = 1'b0;
    logic spi_cs_n_i = 1'b1;
    logic spi_mosi_i = 1'b0;
    logic frame_req_i = 1'b0;
    logic exposure_start_trigger_i = 1'b0;
    logic [11:0] pixel_data_i = 12'hbc7;
    logic [11:0] idle_w = 12'h055;
    logic [11:0] align_w = 12'h0aa;
    logic [11:0] pix_w = 12'h0c7;
    wire spi_miso_o, spi_miso_oe_o, word_strobe_o;
    wire [11:0] ctrl_word_o, data_word_o;
    integer miscompares = 0;
    integer n_tests = 0;
    integer base [0:8];
    always #50 ref_clk_i = ~ref_clk_i;
    srt_timing dut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .spi_clk_i(spi_clk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_mosi_i(spi_mosi_i),
        .spi_miso_o(spi_miso_o),
        .spi_miso_oe_o(spi_miso_oe_o),
        .frame_req_i(frame_req_i),
        .exposure_start_trigger_i(exposure_start_trigger_i),
        .pixel_data_i(pixel_data_i),
        .ctrl_word_o(ctrl_word_o),
        .data_word_o(data_word_o),
        .word_strobe_o(word_strobe_o)
    );
    srt_rx_model rx (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .word_strobe_i(word_strobe_o),
        .ctrl_word_i(ctrl_word_o),
        .data_word_i(data_word_o),
        .idle_word_i(idle_w),
        .align_word_i(align_w),
        .pix_word_i(pix_w)
    );
    // ------------------------------
    // access and compare tasks
    // ------------------------------
    task tick(input integer n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task chk_rng(input string nm, input integer lo, input integer hi, input integer g);
        n_tests++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // serial clock halves are four reference clocks, so the link runs at 800 ns
    task spi(input logic w, input logic [6:0] a, input logic [15:0] v, output logic [15:0] q);
        logic [23:0] s;
        integer i;
        s = {w, a, v};
        q = 16'h0000;
        spi_cs_n_i = 1'b0;
        tick(4);
        for (i = 23; i >= 0; i--) begin
            spi_mosi_i = s[i];
            tick(4);
            spi_clk_i = 1'b1;
            if (i < 16) q = {q[14:0], spi_miso_o & spi_miso_oe_o};
            tick(4);
            spi_clk_i = 1'b0;
        end
        tick(4);
        spi_cs_n_i = 1'b1;
        spi_mosi_i = ~spi_mosi_i;
        tick(8);
    endtask
    task wr(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] q;
        spi(1'b1, a, v, q);
    endtask
    task rd(input string nm, input logic [6:0] a, input logic [15:0] e);
        logic [15:0] q;
        spi(1'b0, a, 16'h0000, q);
        chk(nm, {16'h0, e}, {16'h0, q});
        chk("miso released", 32'h0, {31'h0, spi_miso_oe_o});
    endtask
    function integer d(input integer k);
        d = rx.cnt[k] - base[k];
    endfunction
    task setup(input logic [15:0] cfg, input logic [15:0] ln, input integer fr);
        logic [11:0] m;
        integer i;
        m = cfg[1:0] == 2'h0 ? 12'h0ff : cfg[1:0] == 2'h1 ? 12'h3ff : 12'hfff;
        idle_w = 12'ha5c & m;
        align_w = 12'h0a3 & m;
        pix_w = pixel_data_i & m;
        wr(`SRT_A_CFG, cfg);
        wr(`SRT_A_LINES, ln);
        wr(`SRT_A_FRAMES, fr[15:0]);
        tick(40);
        for (i = 0; i < 9; i++) base[i] = rx.cnt[i];
    endtask
    task run_frame(input integer fr);
        integer i;
        frame_req_i = 1'b1;
        tick(40);
        frame_req_i = 1'b0;
        i = 0;
        while (rx.cnt[6] < base[6] + fr && i < 30000) begin
            tick(1);
            i++;
        end
        tick(40);
    endtask
    task tcase(input logic [15:0] cfg, input logic [15:0] ln, input integer rows, input integer segs, input integer fr);
        setup(cfg, ln, fr);
        run_frame(fr);
        chk("frames", fr, d(2));
        chk("pixel words", fr * rows * segs * 128, d(0));
        chk("line words", fr * rows * (segs * (LEN + 1) - 1), d(1));
        chk("align words", fr * rows, d(5));
        chk("integ words", fr * INTEG, d(3));
        chk("overhead words", fr * OVH, d(4));
        chk("wrong words", 0, d(7));
        chk("rest ctrl", 32'h080, {20'h0, ctrl_word_o});
        chk("rest data", {20'h0, idle_w}, {20'h0, data_word_o});
        $display("test cfg %0h done", cfg);
    endtask
    initial begin
        repeat (95000) @(posedge ref_clk_i);
        miscompares++;
        finish_test;
    end
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        tick(8);
        rst_i = 1'b0;
        tick(4);
        rd("lines", `SRT_A_LINES, 16'h0c00);
        rd("mode", `SRT_A_MODE, 16'h0000);
        rd("exposure", `SRT_A_EXP_LO, 16'h0600);
        rd("frames", `SRT_A_FRAMES, 16'h0001);
        rd("unmapped", 7'h7f, 16'h0000);
        chk("reset ctrl", 32'h080, {20'h0, ctrl_word_o});
        chk("reset data", 32'h055, {20'h0, data_word_o});
        wr(`SRT_A_TP, 16'h0a5c);
        rd("training", `SRT_A_TP, 16'h0a5c);
        wr(`SRT_A_EXP_LO, EXP);
        $display("test registers done");
        tcase(16'h0000, 16'h0002, 1, 1, 2);
        tcase(16'h0004, 16'h0002, 1, 2, 1);
        tcase(16'h0008, 16'h0002, 1, 4, 1);
        tcase(16'h0040, 16'h0004, 1, 1, 1);
        tcase(16'h0080, 16'h0008, 1, 1, 1);
        tcase(16'h0020, 16'h0002, 2, 1, 1);
        tcase(16'h0001, 16'h0002, 1, 1, 1);
        wr(`SRT_A_MODE, 16'h0001);
        rd("mode ext", `SRT_A_MODE, 16'h0001);
        setup(16'h0000, 16'h0002, 2);
        exposure_start_trigger_i = 1'b1;
        tick(640);
        run_frame(1);
        exposure_start_trigger_i = 1'b0;
        tick(4000);
        chk("ext frames", 1, d(2));
        chk_rng("ext integ", 80 + 34 - 1, 80 + 34 + 1, d(3));
        chk("ext wrong", 0, d(7));
        chk("idle lock", 1, {31'h0, rx.cnt[8] > 0});
        $display("test external done");
        finish_test;
    end
endmodule // tb
